/* pftb_cfg.svh */
`ifndef PFTB_CFG_SVH
`define PFTB_CFG_SVH
`define PFTB_REG_BASE 32'h41006000
`define PFTB_OFS_POSITION 4'h0
`define PFTB_OFS_MASTER 4'h4
`define PFTB_OFS_FLOW 4'h8
`define PFTB_OFS_BASE 4'hc
`define PFTB_EN_BIT 31
`define PFTB_WRAP_BIT 2
`define PFTB_STOP_BIT 0
`define PFTB_HALT_BIT 1
`define PFTB_WM_LSB 3
`define PFTB_MASK_W 5
`define PFTB_PTR_RST 29'h0
`define PFTB_MASK_RST 5'h0
`define PFTB_RESP_OKAY 2'h0
`define PFTB_RESP_SLVERR 2'h2
`define PFTB_SEQ_HALF 32'h2
`define PFTB_SEQ_WORD 32'h4
`define PFTB_SRAM_BASE_DFLT 32'h20000000
`define PFTB_SRAM_AW_DFLT 13
`endif

/* pftb_pkg.sv */
package pftb_pkg;
  typedef enum logic [1:0]
  {
    PFTB_IDLE = 2'b00,
    PFTB_SECOND = 2'b01
  } pftb_wr_state_type;
endpackage

/* pftb_buf.sv */
`timescale 1ns/100ps
module pftb_buf #(
  parameter int W = 64
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Filling side
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  // Draining side
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  logic [W-1:0] mem_ff [2];
  logic [1:0] cnt_ff, nxt_cnt;
  logic wr_ff, nxt_wr, rd_ff, nxt_rd;
  logic in_ready_ff, nxt_in_ready, out_valid_ff, nxt_out_valid;
  logic push, pop;

  assign push = in_valid && in_ready_ff;
  assign pop = out_valid_ff && out_ready;
  assign in_ready = in_ready_ff;
  assign out_valid = out_valid_ff;
  assign out_data = mem_ff[rd_ff];

  always_comb
  begin
    nxt_wr = wr_ff ^ push;
    nxt_rd = rd_ff ^ pop;
    nxt_cnt = cnt_ff + {1'b0, push} - {1'b0, pop};
    // Ready from a flop keeps the core's stall path short
    nxt_in_ready = (nxt_cnt != 2'h2);
    nxt_out_valid = (nxt_cnt != 2'h0);
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt_ff <= 2'h0;
      wr_ff <= 1'b0;
      rd_ff <= 1'b0;
      in_ready_ff <= 1'b0;
      out_valid_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      wr_ff <= nxt_wr;
      rd_ff <= nxt_rd;
      in_ready_ff <= nxt_in_ready;
      out_valid_ff <= nxt_out_valid;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (push)
    begin
      mem_ff[wr_ff] <= in_data;
    end
  end
endmodule

/* pftb_top.sv */
// Implementation choices: the address map and the AXI4-Lite slave port.
`timescale 1ns/100ps
`include "pftb_cfg.svh"
// Behaviour
// - When trace and processor want the SRAM in the same cycle, the trace write goes first.
// - Each non-sequential program counter change makes one packet of two 32-bit words.
// - Packets are recorded only while the enable bit is 1, and writing it starts or stops.
// - With stop at threshold set, tracing stops itself when the pointer reaches the watermark.
// - Without threshold stopping, the pointer wraps to the buffer start and overwrites.
// - The register block answers at base 0x41006000, each register at a fixed offset.
// - There are four registers: position, master control, flow control and SRAM base.
// - The position register holds the write pointer and a wrap flag.
// - The flow register holds the watermark plus stop and halt at threshold bits.
// - The base register reports, read-only, where the trace SRAM sits.
// - The processor gets no SRAM access while trace packets are written, and waits.
// - Start and size of the trace region are set by software.
module pftb_top
  import pftb_pkg::*;
#(
  parameter logic [31:0] SRAM_BASE = `PFTB_SRAM_BASE_DFLT,
  parameter int AW = `PFTB_SRAM_AW_DFLT
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Register bus
  input wire logic [31:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Core execution trace
  input wire logic trace_valid,
  input wire logic [31:0] trace_src,
  input wire logic [31:0] trace_dst,
  input wire logic trace_exc,
  output logic trace_ready,
  // Processor SRAM request
  input wire logic cpu_req,
  input wire logic cpu_we,
  input wire logic [AW-1:0] cpu_addr,
  input wire logic [31:0] cpu_wdata,
  input wire logic [3:0] cpu_be,
  output logic cpu_gnt,
  output logic cpu_rvalid,
  output logic [31:0] cpu_rdata,
  // SRAM port
  output logic sram_en,
  output logic sram_we,
  output logic [AW-1:0] sram_addr,
  output logic [31:0] sram_wdata,
  output logic [3:0] sram_be,
  input wire logic [31:0] sram_rdata,
  // Halt request to the core
  output logic halt_req
);
  function automatic logic [2:0] dec(input logic [31:0] a);
    dec = {(a[31:4] == 28'(`PFTB_REG_BASE >> 4)) && (a[1:0] == 2'h0), a[3:2]};
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] d,
                                        input logic [3:0] s);
    for (int i = 0; i < 4; i++)
    begin
      merge[i*8 +: 8] = s[i] ? d[i*8 +: 8] : o[i*8 +: 8];
    end
  endfunction

  function automatic logic [28:0] win(input logic [`PFTB_MASK_W-1:0] m);
    logic [28:0] one;
    one = 29'h1;
    win = (one << ({1'b0, m} + 6'h1)) - 29'h1;
  endfunction

  // Bus slave state
  logic aw_got_ff, nxt_aw_got, w_got_ff, nxt_w_got;
  logic [31:0] aw_addr_ff, nxt_aw_addr, w_data_ff, nxt_w_data;
  logic [3:0] w_strb_ff, nxt_w_strb;
  logic awready_ff, nxt_awready, wready_ff, nxt_wready, bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
  logic arready_ff, nxt_arready, rvalid_ff, nxt_rvalid;
  logic [31:0] rdata_ff, nxt_rdata;
  logic do_write, ar_fire;
  logic [2:0] wdec, rdec;
  logic [31:0] pos_val, mst_val, flow_val;

  // Trace control state
  logic [28:0] ptr_ff, nxt_ptr, wm_ff, nxt_wm, step, mwin;
  logic wrap_ff, nxt_wrap, en_ff, nxt_en, stop_ff, nxt_stop, halt_ff, nxt_halt;
  logic hreq_ff, nxt_hreq;
  logic [`PFTB_MASK_W-1:0] mask_ff, nxt_mask;
  pftb_wr_state_type st_ff, nxt_st;
  logic wrap_now, thr_hit, pkt_done;

  // SRAM side state
  logic sen_ff, nxt_sen, swe_ff, nxt_swe, gnt_ff, nxt_gnt;
  logic rd_pend_ff, nxt_rd_pend, crv_ff, nxt_crv;
  logic rd_wait_ff, nxt_rd_wait;
  logic [AW-1:0] sad_ff, nxt_sad;
  logic [31:0] swd_ff, nxt_swd, crd_ff, nxt_crd;
  logic [3:0] sbe_ff, nxt_sbe;

  // Packet buffer
  logic nonseq, buf_in_valid, buf_in_ready, buf_out_valid, buf_pop;
  logic [63:0] buf_in_data, buf_out_data;

  assign nonseq = (trace_dst != trace_src + `PFTB_SEQ_HALF)
                  && (trace_dst != trace_src + `PFTB_SEQ_WORD);
  assign buf_in_valid = trace_valid && en_ff && nonseq;
  assign buf_in_data = {trace_dst[31:1], 1'b0, trace_src[31:1], trace_exc};
  assign buf_pop = (st_ff == PFTB_SECOND);

  pftb_buf #(
    .W(64)
  ) u_buf (
    .aclk(aclk),
    .aresetn(aresetn),
    .in_valid(buf_in_valid),
    .in_data(buf_in_data),
    .in_ready(buf_in_ready),
    .out_valid(buf_out_valid),
    .out_data(buf_out_data),
    .out_ready(buf_pop)
  );

  assign wdec = dec(aw_addr_ff);
  assign rdec = dec(s_axi_araddr);
  assign do_write = aw_got_ff && w_got_ff && !bvalid_ff;
  assign ar_fire = s_axi_arvalid && arready_ff;
  assign pos_val = {ptr_ff, wrap_ff, 2'h0};
  assign mst_val = {en_ff, 26'h0, mask_ff};
  assign flow_val = {wm_ff, 1'b0, halt_ff, stop_ff};

  always_comb
  begin
    nxt_aw_got = aw_got_ff;
    nxt_aw_addr = aw_addr_ff;
    nxt_w_got = w_got_ff;
    nxt_w_data = w_data_ff;
    nxt_w_strb = w_strb_ff;
    nxt_bvalid = bvalid_ff;
    nxt_bresp = bresp_ff;
    if (s_axi_awvalid && awready_ff)
    begin
      nxt_aw_got = 1'b1;
      nxt_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_ff)
    begin
      nxt_w_got = 1'b1;
      nxt_w_data = s_axi_wdata;
      nxt_w_strb = s_axi_wstrb;
    end
    if (do_write)
    begin
      nxt_aw_got = 1'b0;
      nxt_w_got = 1'b0;
      nxt_bvalid = 1'b1;
      // Base is read-only, so a write to it is refused
      nxt_bresp = (wdec[2] && wdec[1:0] != 2'(`PFTB_OFS_BASE >> 2)) ?
                  `PFTB_RESP_OKAY : `PFTB_RESP_SLVERR;
    end
    else if (bvalid_ff && s_axi_bready)
    begin
      nxt_bvalid = 1'b0;
    end
    nxt_awready = !nxt_aw_got && !nxt_bvalid;
    nxt_wready = !nxt_w_got && !nxt_bvalid;
    nxt_rvalid = rvalid_ff;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    if (ar_fire)
    begin
      nxt_rvalid = 1'b1;
      nxt_rresp = rdec[2] ? `PFTB_RESP_OKAY : `PFTB_RESP_SLVERR;
      case ({rdec[1:0], 2'h0})
        `PFTB_OFS_POSITION: nxt_rdata = pos_val;
        `PFTB_OFS_MASTER: nxt_rdata = mst_val;
        `PFTB_OFS_FLOW: nxt_rdata = flow_val;
        default: nxt_rdata = SRAM_BASE;
      endcase
      if (!rdec[2])
      begin
        nxt_rdata = 32'h0;
      end
    end
    else if (rvalid_ff && s_axi_rready)
    begin
      nxt_rvalid = 1'b0;
    end
    nxt_arready = !nxt_rvalid;
  end

  // Pointer steps inside the software-sized window
  assign mwin = win(mask_ff);
  assign step = (ptr_ff & ~mwin) | ((ptr_ff + 29'h1) & mwin);
  assign wrap_now = ((ptr_ff + 29'h1) & mwin) == 29'h0;
  assign thr_hit = (step == wm_ff);
  assign pkt_done = (st_ff == PFTB_SECOND);

  always_comb
  begin
    nxt_ptr = ptr_ff;
    nxt_wrap = wrap_ff;
    nxt_en = en_ff;
    nxt_mask = mask_ff;
    nxt_wm = wm_ff;
    nxt_stop = stop_ff;
    nxt_halt = halt_ff;
    nxt_hreq = hreq_ff;
    // Software writes first, so the hardware-set wrap flag and halt request below win the same cycle
    if (do_write && wdec[2])
    begin
      case ({wdec[1:0], 2'h0})
        `PFTB_OFS_POSITION:
        begin
          {nxt_ptr, nxt_wrap} = 30'(merge(pos_val, w_data_ff, w_strb_ff) >> `PFTB_WRAP_BIT);
        end
        `PFTB_OFS_MASTER:
        begin
          nxt_en = 1'(merge(mst_val, w_data_ff, w_strb_ff) >> `PFTB_EN_BIT);
          nxt_mask = `PFTB_MASK_W'(merge(mst_val, w_data_ff, w_strb_ff));
        end
        `PFTB_OFS_FLOW:
        begin
          nxt_wm = 29'(merge(flow_val, w_data_ff, w_strb_ff) >> `PFTB_WM_LSB);
          nxt_stop = w_strb_ff[0] ? w_data_ff[`PFTB_STOP_BIT] : stop_ff;
          nxt_halt = w_strb_ff[0] ? w_data_ff[`PFTB_HALT_BIT] : halt_ff;
          nxt_hreq = 1'b0;
        end
        default:
        begin
          nxt_ptr = ptr_ff;
        end
      endcase
    end
    if (pkt_done)
    begin
      if (!(do_write && wdec[2] && wdec[1:0] == 2'h0))
      begin
        nxt_ptr = step;
      end
      if (wrap_now)
      begin
        nxt_wrap = 1'b1;
      end
      // A software enable written this cycle beats the threshold stop
      if (stop_ff && thr_hit && !(do_write && wdec == 3'h5))
      begin
        nxt_en = 1'b0;
      end
      if (halt_ff && thr_hit)
      begin
        nxt_hreq = 1'b1;
      end
    end
  end

  // Trace writes hold the SRAM for two cycles; the processor waits
  always_comb
  begin
    nxt_st = st_ff;
    nxt_sen = 1'b0;
    nxt_swe = 1'b0;
    nxt_sad = sad_ff;
    nxt_swd = swd_ff;
    nxt_sbe = 4'hf;
    nxt_gnt = 1'b0;
    nxt_rd_pend = 1'b0;
    case (st_ff)
      PFTB_IDLE:
      begin
        if (buf_out_valid)
        begin
          nxt_st = PFTB_SECOND;
          nxt_sen = 1'b1;
          nxt_swe = 1'b1;
          nxt_sad = {ptr_ff[AW-2:0], 1'b0};
          nxt_swd = buf_out_data[31:0];
        end
        else if (cpu_req && !gnt_ff)
        begin
          nxt_sen = 1'b1;
          nxt_swe = cpu_we;
          nxt_sad = cpu_addr;
          nxt_swd = cpu_wdata;
          nxt_sbe = cpu_be;
          nxt_gnt = 1'b1;
          nxt_rd_pend = !cpu_we;
        end
      end
      PFTB_SECOND:
      begin
        nxt_st = PFTB_IDLE;
        nxt_sen = 1'b1;
        nxt_swe = 1'b1;
        nxt_sad = {ptr_ff[AW-2:0], 1'b1};
        nxt_swd = buf_out_data[63:32];
      end
      default:
      begin
        nxt_st = PFTB_IDLE;
      end
    endcase
    // SRAM answers one cycle after the command, so data is caught one stage later
    nxt_rd_wait = rd_pend_ff;
    nxt_crv = rd_wait_ff;
    nxt_crd = rd_wait_ff ? sram_rdata : crd_ff;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_ff <= 1'b0;
      aw_addr_ff <= 32'h0;
      w_got_ff <= 1'b0;
      w_data_ff <= 32'h0;
      w_strb_ff <= 4'h0;
      awready_ff <= 1'b0;
      wready_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= `PFTB_RESP_OKAY;
      arready_ff <= 1'b0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0;
      rresp_ff <= `PFTB_RESP_OKAY;
      ptr_ff <= `PFTB_PTR_RST;
      wrap_ff <= 1'b0;
      en_ff <= 1'b0;
      mask_ff <= `PFTB_MASK_RST;
      wm_ff <= `PFTB_PTR_RST;
      stop_ff <= 1'b0;
      halt_ff <= 1'b0;
      hreq_ff <= 1'b0;
      st_ff <= PFTB_IDLE;
      sen_ff <= 1'b0;
      swe_ff <= 1'b0;
      sad_ff <= '0;
      swd_ff <= 32'h0;
      sbe_ff <= 4'h0;
      gnt_ff <= 1'b0;
      rd_pend_ff <= 1'b0;
      rd_wait_ff <= 1'b0;
      crv_ff <= 1'b0;
      crd_ff <= 32'h0;
    end
    else
    begin
      aw_got_ff <= nxt_aw_got;
      aw_addr_ff <= nxt_aw_addr;
      w_got_ff <= nxt_w_got;
      w_data_ff <= nxt_w_data;
      w_strb_ff <= nxt_w_strb;
      awready_ff <= nxt_awready;
      wready_ff <= nxt_wready;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      arready_ff <= nxt_arready;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
      ptr_ff <= nxt_ptr;
      wrap_ff <= nxt_wrap;
      en_ff <= nxt_en;
      mask_ff <= nxt_mask;
      wm_ff <= nxt_wm;
      stop_ff <= nxt_stop;
      halt_ff <= nxt_halt;
      hreq_ff <= nxt_hreq;
      st_ff <= nxt_st;
      sen_ff <= nxt_sen;
      swe_ff <= nxt_swe;
      sad_ff <= nxt_sad;
      swd_ff <= nxt_swd;
      sbe_ff <= nxt_sbe;
      gnt_ff <= nxt_gnt;
      rd_pend_ff <= nxt_rd_pend;
      rd_wait_ff <= nxt_rd_wait;
      crv_ff <= nxt_crv;
      crd_ff <= nxt_crd;
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;
  assign trace_ready = buf_in_ready;
  assign cpu_gnt = gnt_ff;
  assign cpu_rvalid = crv_ff;
  assign cpu_rdata = crd_ff;
  assign sram_en = sen_ff;
  assign sram_we = swe_ff;
  assign sram_addr = sad_ff;
  assign sram_wdata = swd_ff;
  assign sram_be = sbe_ff;
  assign halt_req = hreq_ff;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_trace_first: assert property (pkt_done |=> sram_we && !cpu_gnt)
    else $error("trace second word lost SRAM");
  a_packet_pair: assert property (st_ff == PFTB_IDLE && buf_out_valid
    |=> sram_we && !sram_addr[0] ##1 sram_we && sram_addr[0])
    else $error("packet not two words");
  a_enable_write: assert property (do_write && wdec == 3'h5 && w_strb_ff[3]
    |=> en_ff == $past(w_data_ff[31]))
    else $error("enable write ignored");
  a_auto_stop: assert property (pkt_done && stop_ff && thr_hit && !do_write
    |=> !en_ff)
    else $error("no stop at watermark");
  a_wrap_flag: assert property (pkt_done && wrap_now && !do_write
    |=> wrap_ff && (ptr_ff & mwin) == 29'h0)
    else $error("wrap not taken");
  a_bad_addr: assert property (ar_fire && !rdec[2]
    |=> s_axi_rvalid && s_axi_rresp == 2'h2)
    else $error("unmapped read not refused");
  a_base_read: assert property (ar_fire && rdec == 3'h7
    |=> s_axi_rdata == SRAM_BASE)
    else $error("base register wrong");
  a_cpu_served: assert property (cpu_req && st_ff == PFTB_IDLE && !buf_out_valid
    && !gnt_ff |=> cpu_gnt ##2 (cpu_rvalid || $past(cpu_we, 3)))
    else $error("processor access starved");
  a_ptr_step: assert property (pkt_done && !do_write
    |=> (ptr_ff & mwin) == (($past(ptr_ff) + 29'h1) & mwin))
    else $error("pointer step wrong");

  c_packet: cover property (pkt_done);
  c_wrap: cover property (pkt_done && wrap_now);
  c_stop: cover property ($fell(en_ff) && $past(pkt_done));
  c_cpu_read: cover property (cpu_rvalid);
endmodule

/* pftb_sram_model.sv */
`timescale 1ns/100ps
module pftb_sram_model #(
  parameter int AW = 13
) (
  // Clock
  input wire logic aclk,
  // SRAM command
  input wire logic sram_en,
  input wire logic sram_we,
  input wire logic [AW-1:0] sram_addr,
  input wire logic [31:0] sram_wdata,
  input wire logic [3:0] sram_be,
  // Answer and write tally
  output logic [31:0] sram_rdata,
  output int wr_count
);
  logic [31:0] mem [2**AW];
  initial
  begin
    sram_rdata = 32'h0;
    wr_count = 0;
  end
  // Read data lasts one cycle, then scrambles so stale data never passes
  always @(posedge aclk)
  begin
    if (sram_en && !sram_we)
      sram_rdata <= mem[sram_addr];
    else
      sram_rdata <= ~sram_rdata;
    if (sram_en && sram_we)
    begin
      for (int b = 0; b < 4; b++)
        if (sram_be[b])
          mem[sram_addr][8*b +: 8] <= sram_wdata[8*b +: 8];
      wr_count <= wr_count + 1;
    end
  end
endmodule

/* test_program_flow_trace_buffer.sv */
`timescale 1ns/100ps
`include "pftb_cfg.svh"
module test_program_flow_trace_buffer;
  localparam int AW = 13;
  localparam logic [31:0] RB = `PFTB_REG_BASE;
  localparam logic [31:0] SB = 32'h20000000;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0, s_axi_araddr = 32'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata, cpu_rdata, sram_rdata, sram_wdata;
  logic trace_valid = 1'h0, trace_exc = 1'h0, cpu_req = 1'h0, cpu_we = 1'h0;
  logic [31:0] trace_src = 32'h0, trace_dst = 32'h0, cpu_wdata = 32'h0;
  logic [AW-1:0] cpu_addr = 13'h0, sram_addr;
  logic trace_ready, cpu_gnt, cpu_rvalid, sram_en, sram_we, halt_req;
  logic [3:0] sram_be;
  int mdl_wr, miscompares = 0, cmp_count = 0, wcnt = 0, refused = 0, seed, gw;
  logic [28:0] ptr = 29'h8;
  logic wrap = 1'h0;
  logic [31:0] ss [4], dd [4], q, s, d;
  logic xx [4], x;

  pftb_top #(.SRAM_BASE(SB), .AW(AW)) dut (.aclk, .aresetn, .s_axi_awaddr,
    .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hf),
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .trace_valid, .trace_src, .trace_dst, .trace_exc,
    .trace_ready, .cpu_req, .cpu_we, .cpu_addr, .cpu_wdata, .cpu_be(4'hf), .cpu_gnt,
    .cpu_rvalid, .cpu_rdata, .sram_en, .sram_we, .sram_addr, .sram_wdata, .sram_be,
    .sram_rdata, .halt_req);
  pftb_sram_model #(.AW(AW)) mdl (.aclk, .sram_en, .sram_we, .sram_addr, .sram_wdata,
    .sram_be, .sram_rdata, .wr_count(mdl_wr));

  always #5 aclk = ~aclk;

  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Every handshake wait passes through here, so no handshake can hang the run
  task automatic tick(inout int n);
    @(posedge aclk);
    n++;
    if (n > 300)
    begin
      miscompares++;
      $display("Error at %0t: wait ran out", $time);
      finish_test();
    end
  endtask
  task automatic wr(input logic [31:0] o, input logic [31:0] dv, input logic [1:0] er);
    int n;
    bit da, dw;
    n = 0;
    da = 0;
    dw = 0;
    s_axi_awaddr <= RB + o;
    s_axi_wdata <= dv;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    while (!(da && dw))
    begin
      tick(n);
      da |= (s_axi_awready === 1'h1);
      dw |= (s_axi_wready === 1'h1);
      s_axi_awvalid <= !da;
      s_axi_wvalid <= !dw;
    end
    s_axi_bready <= 1'h1;
    do tick(n); while (s_axi_bvalid !== 1'h1);
    s_axi_bready <= 1'h0;
    chk({30'h0, s_axi_bresp}, {30'h0, er});
  endtask
  task automatic rdchk(input logic [31:0] o, input logic [31:0] e, input logic [1:0] er);
    int n;
    n = 0;
    s_axi_araddr <= RB + o;
    s_axi_arvalid <= 1'h1;
    do tick(n); while (s_axi_arready !== 1'h1);
    s_axi_arvalid <= 1'h0;
    s_axi_rready <= 1'h1;
    do tick(n); while (s_axi_rvalid !== 1'h1);
    s_axi_rready <= 1'h0;
    chk(s_axi_rdata, e);
    chk({30'h0, s_axi_rresp}, {30'h0, er});
  endtask
  // Valid stays up between back-to-back changes unless this is the last
  task automatic trc(input logic [31:0] sv, input logic [31:0] dv, input logic xv, input bit last);
    int n;
    n = 0;
    trace_src <= sv;
    trace_dst <= dv;
    trace_exc <= xv;
    trace_valid <= 1'h1;
    do
    begin
      tick(n);
      refused += (trace_ready !== 1'h1);
    end
    while (trace_ready !== 1'h1);
    if (last)
      trace_valid <= 1'h0;
  endtask
  task automatic rnd(output logic [31:0] sv, output logic [31:0] dv, output logic xv);
    sv = $urandom;
    dv = sv + 32'h8 + 32'h2 * ($urandom % 256);
    xv = $urandom % 2;
  endtask
  function automatic logic [28:0] nxt(input logic [28:0] p);
    // Size code 1 gives a window of four packets
    return (p & ~29'h3) | ((p + 29'h1) & 29'h3);
  endfunction
  task automatic expect_pkt(input logic [31:0] sv, input logic [31:0] dv, input logic xv);
    int n;
    n = 0;
    wcnt += 2;
    while (mdl_wr < wcnt) tick(n);
    chk(mdl.mem[{ptr[AW-2:0], 1'h0}], {sv[31:1], xv});
    chk(mdl.mem[{ptr[AW-2:0], 1'h1}], {dv[31:1], 1'h0});
    ptr = nxt(ptr);
    wrap |= (ptr[1:0] == 2'h0);
  endtask
  task automatic cpu(input logic w, input logic [AW-1:0] a, input logic [31:0] dv);
    int n;
    n = 0;
    cpu_req <= 1'h1;
    cpu_we <= w;
    cpu_addr <= a;
    cpu_wdata <= dv;
    do tick(n); while (cpu_gnt !== 1'h1);
    gw = mdl_wr;
    cpu_req <= 1'h0;
    if (w)
      wcnt++;
    else
      do tick(n); while (cpu_rvalid !== 1'h1);
    q = cpu_rdata;
  endtask

  initial
  begin
    seed = $urandom(99);
    repeat (6) @(posedge aclk);
    aresetn <= 1'h1;
    repeat (2) @(posedge aclk);
    rdchk(`PFTB_OFS_BASE, SB, `PFTB_RESP_OKAY);
    rdchk(`PFTB_OFS_POSITION, 32'h0, `PFTB_RESP_OKAY);
    rdchk(`PFTB_OFS_MASTER, 32'h0, `PFTB_RESP_OKAY);
    rdchk(32'h10, 32'h0, `PFTB_RESP_SLVERR);
    rdchk(32'h6, 32'h0, `PFTB_RESP_SLVERR);
    wr(`PFTB_OFS_BASE, 32'h12340000, `PFTB_RESP_SLVERR);
    rdchk(`PFTB_OFS_BASE, SB, `PFTB_RESP_OKAY);
    wr(`PFTB_OFS_POSITION, {ptr, 3'h0}, `PFTB_RESP_OKAY);
    wr(`PFTB_OFS_MASTER, 32'h80000001, `PFTB_RESP_OKAY);
    // Random changes, with both sequential steps dropped on the way
    for (int i = 0; i < 6; i++)
    begin
      rnd(s, d, x);
      if (i == 2 || i == 4)
      begin
        trc(s, s + 32'(i), x, 1);
        repeat (8) @(posedge aclk);
        chk(mdl_wr, wcnt);
      end
      trc(s, d, x, 1);
      expect_pkt(s, d, x);
    end
    rdchk(`PFTB_OFS_POSITION, {ptr, wrap, 2'h0}, `PFTB_RESP_OKAY);
    // Back-to-back changes fill the two-entry buffer until it refuses
    refused = 0;
    for (int i = 0; i < 4; i++)
    begin
      rnd(ss[i], dd[i], xx[i]);
      trc(ss[i], dd[i], xx[i], i == 3);
    end
    for (int i = 0; i < 4; i++)
      expect_pkt(ss[i], dd[i], xx[i]);
    chk(32'(refused != 0), 32'h1);
    // Processor waits behind a pending packet, then reads it back
    cpu(1'h1, 13'h100, s);
    cpu(1'h0, 13'h100, 32'h0);
    chk(q, s);
    rnd(s, d, x);
    trc(s, d, x, 1);
    cpu(1'h0, {ptr[AW-2:0], 1'h0}, 32'h0);
    chk(gw, wcnt + 2);
    chk(q, {s[31:1], x});
    expect_pkt(s, d, x);
    // Stop and halt two packets ahead
    wr(`PFTB_OFS_FLOW, {nxt(nxt(ptr)), 3'h3}, `PFTB_RESP_OKAY);
    for (int i = 0; i < 2; i++)
    begin
      rnd(s, d, x);
      trc(s, d, x, 1);
      expect_pkt(s, d, x);
    end
    rdchk(`PFTB_OFS_MASTER, 32'h1, `PFTB_RESP_OKAY);
    chk({31'h0, halt_req}, 32'h1);
    trc(s, d, x, 1);
    repeat (8) @(posedge aclk);
    chk(mdl_wr, wcnt);
    wr(`PFTB_OFS_FLOW, 32'h0, `PFTB_RESP_OKAY);
    chk({31'h0, halt_req}, 32'h0);
    wr(`PFTB_OFS_MASTER, 32'h80000001, `PFTB_RESP_OKAY);
    rnd(s, d, x);
    trc(s, d, x, 1);
    expect_pkt(s, d, x);
    wr(`PFTB_OFS_MASTER, 32'h1, `PFTB_RESP_OKAY);
    trc(s, d, x, 1);
    repeat (8) @(posedge aclk);
    chk(mdl_wr, wcnt);
    finish_test();
  end
endmodule
